// *** inc/nvs_params.svh ***
// constants of the serial command front end
`ifndef NVS_PARAMS_SVH
`define NVS_PARAMS_SVH

// opcode values
`define NVS_OP_SET_WRITE_ENABLE_CMD_VAL 8'h06
`define NVS_OP_CLEAR_WRITE_ENABLE_CMD_VAL 8'h04
`define NVS_OP_WRITE 8'h02
`define NVS_OP_READ 8'h03
`define NVS_OP_SEC_WRITE 8'h12
`define NVS_OP_SEC_READ 8'h13
`define NVS_OP_SR_WRITE 8'h01
`define NVS_OP_SR_READ 8'h05
`define NVS_OP_STORE 8'h08
`define NVS_OP_RECALL 8'h09
`define NVS_OP_USR_WRITE 8'hC2
`define NVS_OP_USR_READ 8'hC3
`define NVS_OP_HIBERNATE 8'hB9

// frame lengths in bytes
`define NVS_ADDR_BYTES 2
`define NVS_CRC_BYTES 64
`define NVS_USER_BYTES 16

// write enable latch position in the status byte
`define NVS_WEL_BIT 1

// pin positions in the synchroniser vector and their idle levels
`define NVS_PIN_SCK 0
`define NVS_PIN_CS 1
`define NVS_PIN_SI 2
`define NVS_PIN_HOLD 3
`define NVS_PIN_COUNT 4
`define NVS_PIN_IDLE 4'hA

`endif

// *** inc/nvs_pkg.sv ***
// types shared by the serial command front end
package nvs_pkg;
  `include "nvs_params.svh"

  // frame phase, one-hot
  typedef enum logic [4:0] {
    PH_OPCODE = 5'h01,
    PH_ADDR = 5'h02,
    PH_DATA = 5'h04,
    PH_IGNORE = 5'h08,
    PH_SPARE = 5'h10
  } nvs_phase_t;

  // decoded instruction set
  typedef enum logic [7:0] {
    OP_SET_WE = `NVS_OP_SET_WRITE_ENABLE_CMD_VAL,
    OP_CLR_WE = `NVS_OP_CLEAR_WRITE_ENABLE_CMD_VAL,
    OP_WRITE = `NVS_OP_WRITE,
    OP_READ = `NVS_OP_READ,
    OP_SEC_WRITE = `NVS_OP_SEC_WRITE,
    OP_SEC_READ = `NVS_OP_SEC_READ,
    OP_SR_WRITE = `NVS_OP_SR_WRITE,
    OP_SR_READ = `NVS_OP_SR_READ,
    OP_STORE = `NVS_OP_STORE,
    OP_RECALL = `NVS_OP_RECALL,
    OP_USR_WRITE = `NVS_OP_USR_WRITE,
    OP_USR_READ = `NVS_OP_USR_READ,
    OP_HIBERNATE = `NVS_OP_HIBERNATE
  } nvs_op_t;
endpackage

// *** inc/nvs_pin_if.sv ***
// raw and filtered pin levels between synchroniser and core
`timescale 1ns/1ps
interface nvs_pin_if;
  logic [3:0] raw;
  logic [3:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

// *** verilog/nvs_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module nvs_pin_sync #(
  parameter int W = 4,
  parameter logic [3:0] IDLE = 4'hA
) (
  input wire logic ref_clk,
  input wire logic nrst,
  nvs_pin_if.sync pins
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] level;

  // ff1 feeds only ff2; the filter looks at ff2 and ff3
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ff1 <= IDLE[W-1:0];
      ff2 <= IDLE[W-1:0];
      ff3 <= IDLE[W-1:0];
    end else begin
      ff1 <= pins.raw;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // a change counts once two stages agree
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      level <= IDLE[W-1:0];
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          level[i] <= ff3[i];
        end
      end
    end
  end

  assign pins.clean = level;
endmodule // nvs_pin_sync

// *** verilog/nvs_frontend.sv ***
// serial slave command front end of the backed-up sram
`timescale 1ns/1ps
`include "nvs_params.svh"
module nvs_frontend #(
  parameter int ADDR_BYTES = `NVS_ADDR_BYTES,
  parameter int CRC_BYTES = `NVS_CRC_BYTES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  output logic so_out,
  output logic so_oe,
  input wire logic [7:0] status_in,
  input wire logic [7:0] tx_data,
  output logic tx_req,
  input wire logic protect_hit,
  output nvs_pkg::nvs_op_t opcode,
  output logic opcode_valid,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_is_addr,
  output logic cmd_done,
  output logic cmd_abort,
  output logic write_enable_latch
);
  import nvs_pkg::*;

  nvs_pin_if pins ();
  logic sck_s, cs_n_s, si_s, hold_s;
  logic sck_q, cs_q;
  logic sck_rise, sck_fall, cs_rise, sel;
  logic paused;
  nvs_phase_t phase;
  logic [2:0] bit_cnt;
  logic [7:0] addr_left;
  logic [7:0] data_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [7:0] tx_sh;
  logic [7:0] tx_byte;
  logic out_act;
  logic byte_done;
  logic [7:0] op_eff;
  logic tx_load;
  logic len_ok;
  logic wel_set, wel_clr;
  logic is_wr;

  // pins from outside pass three stages and a filter register before use
  assign pins.raw = {hold_n, si, cs_n, sck};

  nvs_pin_sync #(
    .W(`NVS_PIN_COUNT),
    .IDLE(`NVS_PIN_IDLE)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pins(pins)
  );

  assign sck_s = pins.clean[`NVS_PIN_SCK];
  assign cs_n_s = pins.clean[`NVS_PIN_CS];
  assign si_s = pins.clean[`NVS_PIN_SI];
  assign hold_s = pins.clean[`NVS_PIN_HOLD];

  // previous levels for edge finding
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      cs_q <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_q;
  assign sck_fall = ~sck_s & sck_q;
  assign cs_rise = cs_n_s & ~cs_q;
  assign sel = ~cs_n_s;

  // opcode class helpers
  function automatic logic has_addr(input logic [7:0] op);
    has_addr = (op == `NVS_OP_WRITE) || (op == `NVS_OP_READ) ||
               (op == `NVS_OP_SEC_WRITE) || (op == `NVS_OP_SEC_READ);
  endfunction

  function automatic logic has_data(input logic [7:0] op);
    has_data = (op == `NVS_OP_SR_WRITE) || (op == `NVS_OP_SR_READ) ||
               (op == `NVS_OP_USR_WRITE) || (op == `NVS_OP_USR_READ);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `NVS_OP_READ) || (op == `NVS_OP_SEC_READ) ||
              (op == `NVS_OP_SR_READ) || (op == `NVS_OP_USR_READ);
  endfunction

  // pause tracking; hold level is the sampled pin
  // enter only selected
  always_ff @(posedge ref_clk) begin
    if (!nrst || !sel) begin
      paused <= 1'b0;
    end else if (!sck_s) begin
      paused <= ~hold_s;
    end
  end

  assign next_sh = {sh[6:0], si_s};
  assign byte_done = sel && sck_rise && !paused && (bit_cnt == 3'h7);
  assign op_eff = (phase == PH_OPCODE) ? next_sh : opcode;

  // load read data once the header is in
  assign tx_load = byte_done && is_read(op_eff) &&
    ((phase == PH_OPCODE && !has_addr(next_sh)) ||
     (phase == PH_ADDR && addr_left == 8'h00) ||
     (phase == PH_DATA));
  assign tx_req = tx_load;

  always_comb begin
    tx_byte = tx_data;
    if (op_eff == `NVS_OP_SR_READ) begin
      tx_byte = status_in;
      tx_byte[`NVS_WEL_BIT] = write_enable_latch;
    end
  end

  // frame phase and counters
  // deselect restarts at the opcode
  always_ff @(posedge ref_clk) begin
    if (!nrst || cs_n_s) begin
      phase <= PH_OPCODE;
      bit_cnt <= 3'h0;
      addr_left <= 8'h00;
      data_cnt <= 8'h00;
      sh <= 8'h00;
    end else if (sck_rise && !paused) begin
      // first rise after select is bit 7
      sh <= next_sh;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        case (phase)
          PH_OPCODE: begin
            if (has_addr(next_sh)) begin
              phase <= PH_ADDR;
              addr_left <= 8'(ADDR_BYTES - 1);
            end else if (has_data(next_sh)) begin
              phase <= PH_DATA;
            end else begin
              phase <= PH_IGNORE;
            end
          end
          PH_ADDR: begin
            if (addr_left == 8'h00) begin
              phase <= PH_DATA;
            end else begin
              addr_left <= addr_left - 8'h01;
            end
          end
          PH_DATA: begin
            if (data_cnt != 8'hFF) begin
              data_cnt <= data_cnt + 8'h01;
            end
          end
          default: begin
            phase <= PH_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      opcode <= OP_CLR_WE;
      opcode_valid <= 1'b0;
    end else if (cs_n_s) begin
      opcode_valid <= 1'b0;
    end else if (byte_done && phase == PH_OPCODE) begin
      opcode <= nvs_op_t'(next_sh);
      opcode_valid <= 1'b1;
    end
  end

  // received address and data bytes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      rx_is_addr <= 1'b0;
    end else begin
      rx_valid <= byte_done && (phase == PH_ADDR || phase == PH_DATA);
      if (byte_done) begin
        rx_byte <= next_sh;
        rx_is_addr <= (phase == PH_ADDR);
      end
    end
  end

  // output shifter, updated on falling clock
  always_ff @(posedge ref_clk) begin
    if (!nrst || cs_n_s) begin
      tx_sh <= 8'h00;
      so_out <= 1'b0;
      out_act <= 1'b0;
    end else if (tx_load) begin
      tx_sh <= tx_byte;
      out_act <= 1'b1;
    end else if (sck_fall && out_act && !paused) begin
      so_out <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // off at once when hold drops
  assign so_oe = sel && hold_s && !paused && out_act;

  // length check at frame close
  // crc write frames need the exact count
  // user space write needs all sixteen
  always_comb begin
    len_ok = (bit_cnt == 3'h0) && opcode_valid;
    case (opcode)
      OP_WRITE, OP_SR_WRITE: len_ok = len_ok && (data_cnt != 8'h00);
      OP_SEC_WRITE: len_ok = len_ok && (data_cnt == 8'(CRC_BYTES));
      OP_USR_WRITE: len_ok = len_ok &&
                             (data_cnt == 8'(`NVS_USER_BYTES));
      default: len_ok = len_ok;
    endcase
  end

  assign is_wr = (opcode == OP_WRITE) || (opcode == OP_SR_WRITE) ||
                 (opcode == OP_SEC_WRITE);

  // frame result pulses
  // store, recall complete here
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cmd_done <= 1'b0;
      cmd_abort <= 1'b0;
    end else begin
      cmd_done <= cs_rise && hold_s && len_ok &&
                  (!is_wr || write_enable_latch);
      cmd_abort <= cs_rise && !hold_s;
    end
  end

  // set when the set frame closes
  assign wel_set = cs_rise && hold_s && len_ok && opcode == OP_SET_WE;
  assign wel_clr = protect_hit || (cs_rise && !hold_s) ||
    (cs_rise && hold_s && len_ok &&
     (opcode == OP_CLR_WE || (is_wr && write_enable_latch)));

  // latch: set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      write_enable_latch <= 1'b0;
    end else if (wel_set) begin
      write_enable_latch <= 1'b1;
    end else if (wel_clr) begin
      write_enable_latch <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_set_close;
    cs_rise && hold_s && len_ok && opcode == OP_SET_WE;
  endsequence

  sequence s_last_bit;
    sck_rise && sel && !paused && bit_cnt == 3'h7;
  endsequence

  a_desel_hiz: assert property (!sel |-> !so_oe)
    else $error("output driven while deselected");

  a_pause_hiz: assert property (paused || !hold_s |-> !so_oe)
    else $error("output driven while paused");

  a_pause_enter: assert property (
    sel && !sck_s && !hold_s ##1 sel |-> paused)
    else $error("pause not entered at clock low");

  a_pause_leave: assert property (
    paused && !sck_s && hold_s |=> !paused)
    else $error("pause not left at clock low");

  a_pause_freeze: assert property (
    paused && sel |=> $stable(bit_cnt) || !sel)
    else $error("bits counted while paused");

  a_desel_reset: assert property (cs_n_s |=> bit_cnt == 3'h0 &&
    phase == PH_OPCODE)
    else $error("counters not reset on deselect");

  a_opcode_take: assert property (
    s_last_bit and phase == PH_OPCODE |=>
      opcode == $past(next_sh) && opcode_valid)
    else $error("opcode not captured");

  a_set_latch: assert property (s_set_close |=> write_enable_latch)
    else $error("latch not set at frame close");

  a_abort_clear: assert property (
    cs_rise && !hold_s |=> !write_enable_latch && cmd_abort && !cmd_done)
    else $error("hold abort did not clear latch");

  a_protect_clear: assert property (
    protect_hit && !wel_set |=> !write_enable_latch)
    else $error("protection hit left latch set");

  a_msb_out: assert property (
    sck_fall && out_act && !paused && sel && !tx_load |=>
      so_out == $past(tx_sh[7]))
    else $error("output bit order wrong");

  a_first_load: assert property (
    tx_load |=> out_act && tx_sh == $past(tx_byte))
    else $error("read byte not loaded");

  a_status_wel: assert property (
    tx_load && op_eff == `NVS_OP_SR_READ |=>
      tx_sh[`NVS_WEL_BIT] == $past(write_enable_latch))
    else $error("status byte lacks latch bit");
endmodule // nvs_frontend

// *** bench/nvs_host_model.sv ***
// serial host model that drives the front end's link pins
`timescale 1ns/1ps
module nvs_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so_out,
  input wire logic so_oe
);
  localparam int HALF = 40;
  // host owns the clock, idle low (mode 0)
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic sel();
    cs_n = 1'b0;
    #(HALF);
  endtask
  task automatic desel();
    #(HALF);
    cs_n = 1'b1;
    si = ~si; // released line must not keep its last value
    #(8 * HALF);
  endtask
  // n bits msb first, data set while low
  task automatic shift(input logic [7:0] d, input int n,
                       output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = d[i];
      #(HALF);
      sck = 1'b1;
      #(HALF);
      // sampled late: the answer passes a synchroniser first
      q = {q[6:0], so_oe ? so_out : 1'bx};
      sck = 1'b0;
    end
  endtask
  // clock and data activity that the device has to ignore
  task automatic junk();
    repeat (4) begin
      si = ~si;
      sck = 1'b1;
      #(HALF);
      sck = 1'b0;
      #(HALF);
    end
  endtask
  // pause control, changed only while the clock is low
  task automatic hold(input logic lvl);
    hold_n = lvl;
    #(2 * HALF);
  endtask
endmodule // nvs_host_model

// *** bench/tb_top.sv ***
// self-checking bench of the serial command front end
`timescale 1ns/1ps
module tb_top;
  import nvs_pkg::*;
  localparam int CRC_N = 4;
  logic ref_clk, nrst, sck, cs_n, si, hold_n, so_out, so_oe;
  logic [7:0] status_in, tx_data, rx_byte, got_rd;
  logic tx_req, protect_hit, opcode_valid, rx_valid, rx_is_addr;
  logic cmd_done, cmd_abort, write_enable_latch, got_stb, rx_mute, wel_m;
  nvs_op_t opcode;
  logic [10:0] exp_q[$];
  int fails, tests_run, tx_seen;
  integer seed;

  nvs_frontend #(.ADDR_BYTES(2), .CRC_BYTES(CRC_N)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe),
    .status_in(status_in), .tx_data(tx_data), .tx_req(tx_req),
    .protect_hit(protect_hit), .opcode(opcode),
    .opcode_valid(opcode_valid), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_is_addr(rx_is_addr), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
    .write_enable_latch(write_enable_latch)
  );
  nvs_host_model i_host (
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe)
  );

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic take(input logic [10:0] got);
    if (exp_q.size() == 0) begin
      fails++;
      $display("unexpected at %0t: stray result %h", $time, got);
    end else begin
      chk(got, exp_q.pop_front());
    end
  endtask

  // watcher: results are registered pulses, so mid-cycle sampling is safe
  always @(negedge ref_clk) begin
    if (nrst) begin
      if (rx_valid && !rx_mute) take({2'd0, rx_byte, rx_is_addr});
      if (cmd_done) take({2'd1, opcode, write_enable_latch});
      if (cmd_abort) take({2'd2, 8'h00, write_enable_latch});
      if (got_stb) take({2'd3, got_rd, 1'b0});
      if (tx_req) tx_seen++;
    end
  end

  // hand a read byte to the watcher for one cycle
  task automatic post_rd(input logic [7:0] q);
    got_rd = q;
    @(posedge ref_clk) #1 got_stb = 1'b1;
    @(posedge ref_clk) #1 got_stb = 1'b0;
  endtask

  // one whole frame: opcode, address, write bytes, read bytes
  task automatic frame(input logic [7:0] op, input int na, input int nw,
                       input int nr, input logic dn);
    logic [7:0] q, b, rx;
    int t0;
    status_in = 8'($random(seed));
    tx_data = 8'($random(seed));
    t0 = tx_seen;
    i_host.sel();
    i_host.shift(op, 8, q);
    for (int i = 0; i < na + nw; i++) begin
      b = 8'($random(seed));
      exp_q.push_back({2'd0, b, i < na});
      i_host.shift(b, 8, q);
    end
    rx = (op == 8'h05) ? {status_in[7:2], wel_m, status_in[0]} : tx_data;
    // the last header byte lands after the shift returns, so no muting
    // here; the host idles si at zero, each read slot comes in as 00
    for (int i = 0; i < nr; i++) begin
      exp_q.push_back({2'd0, 8'h00, 1'b0});
      exp_q.push_back({2'd3, rx, 1'b0});
      i_host.shift(8'h00, 8, q);
      post_rd(q);
    end
    if (op == 8'h06) wel_m = 1'b1;
    if (op == 8'h04 || (dn && (op == 8'h02 || op == 8'h01 || op == 8'h12)))
      wel_m = 1'b0;
    if (dn) exp_q.push_back({2'd1, op, wel_m});
    i_host.desel();
    // one load at the header end, then one per read byte
    chk(11'(tx_seen - t0), 11'(nr > 0 ? nr + 1 : 0));
  endtask

  task automatic end_of_test();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run of about 75 us
  initial begin
    #900000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [7:0] ops[7];
    logic [7:0] q, q2;
    ops = '{8'h06, 8'h04, 8'h06, 8'h08, 8'h09, 8'hB9, 8'h04};
    seed = 32'hE99B4339;
    {nrst, protect_hit, got_stb, rx_mute, wel_m} = 5'h00;
    status_in = 8'h00;
    tx_data = 8'h00;
    got_rd = 8'h00;
    repeat (10) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({so_oe, opcode_valid, write_enable_latch}, 11'h000);
    i_host.junk();
    chk({so_oe, opcode_valid}, 11'h000);
    $display("test reset and deselect done");
    // every no-payload opcode in turn
    foreach (ops[i]) frame(ops[i], 0, 0, 0, 1'b1);
    $display("test control opcodes done");
    // memory, status and crc writes without the latch are refused
    frame(8'h02, 2, 1, 0, 1'b0);
    frame(8'h01, 0, 1, 0, 1'b0);
    frame(8'h12, 2, CRC_N, 0, 1'b0);
    // writes with the latch complete and clear it; the user space write completes without it
    frame(8'h06, 0, 0, 0, 1'b1);
    frame(8'h02, 2, 3, 0, 1'b1);
    frame(8'h06, 0, 0, 0, 1'b1);
    frame(8'h01, 0, 1, 0, 1'b1);
    frame(8'h06, 0, 0, 0, 1'b1);
    frame(8'h12, 2, CRC_N, 0, 1'b1);
    frame(8'hC2, 0, 16, 0, 1'b1);
    $display("test writes done");
    frame(8'h06, 0, 0, 0, 1'b1);
    frame(8'h05, 0, 0, 1, 1'b1);
    frame(8'h03, 2, 0, 2, 1'b1);
    frame(8'h13, 2, 0, CRC_N, 1'b1);
    frame(8'hC3, 0, 0, 16, 1'b1);
    $display("test reads done");
    // partial byte is dropped, next frame decodes afresh
    i_host.sel();
    i_host.shift(8'h04, 5, q);
    i_host.desel();
    chk(write_enable_latch, 11'h001);
    frame(8'h04, 0, 0, 0, 1'b1);
    // protection hit clears the latch
    frame(8'h06, 0, 0, 0, 1'b1);
    @(posedge ref_clk) #1 protect_hit = 1'b1;
    @(posedge ref_clk) #1 protect_hit = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(write_enable_latch, 11'h000);
    wel_m = 1'b0;
    $display("test partial and protect done");
    // pause in mid read byte
    status_in = 8'($random(seed));
    rx_mute = 1'b1;
    exp_q.push_back({2'd3, status_in[7:2], wel_m, status_in[0], 1'b0});
    i_host.sel();
    i_host.shift(8'h05, 8, q);
    i_host.shift(8'h00, 4, q);
    i_host.hold(1'b0);
    chk(so_oe, 11'h000);
    i_host.junk();
    chk(so_oe, 11'h000);
    i_host.hold(1'b1);
    i_host.shift(8'h00, 4, q2);
    post_rd({q[3:0], q2[3:0]});
    exp_q.push_back({2'd1, 8'h05, wel_m});
    i_host.desel();
    rx_mute = 1'b0;
    // deselect while paused aborts and clears the latch
    frame(8'h06, 0, 0, 0, 1'b1);
    i_host.sel();
    i_host.shift(8'h02, 8, q);
    i_host.hold(1'b0);
    exp_q.push_back({2'd2, 8'h00, 1'b0});
    i_host.desel();
    i_host.hold(1'b1);
    wel_m = 1'b0;
    frame(8'h04, 0, 0, 0, 1'b1);
    $display("test pause and abort done");
    repeat (10) @(posedge ref_clk);
    chk(11'(exp_q.size()), 11'h000);
    end_of_test();
  end
endmodule // tb_top
